// ===== shared/aack_pkg.sv
// package: register map, fields, timing and types for the auto-ack receive options block
package aack_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 50;
  localparam int SYMBOL_NS = 16000;
  localparam int SYMBOL_CYC = SYMBOL_NS / CLK_NS;
  localparam int ACK_STD_SYMBOLS = 12;
  localparam int ACK_SHORT_NS = 32000;
  localparam int ACK_READY_SYMBOLS = 3;
  localparam int TRIG_TO_TX_NS = 16000;
  localparam int ACK_STD_CYC = ACK_STD_SYMBOLS * SYMBOL_CYC;
  localparam int ACK_SHORT_CYC = ACK_SHORT_NS / CLK_NS;
  localparam int ACK_READY_CYC = ACK_READY_SYMBOLS * SYMBOL_CYC;
  localparam int TRIG_TO_TX_CYC = (TRIG_TO_TX_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 13;

  // ---------------------------------------------------------------
  // register map (register port addresses)
  // ---------------------------------------------------------------
  localparam logic [5:0] ADDR_SIGNAL_STRENGTH = 6'h06;
  localparam logic [5:0] ADDR_EXT_ACK_CTRL = 6'h17;
  localparam logic [5:0] ADDR_EXT_RETRY_CTRL = 6'h2c;
  localparam logic [5:0] ADDR_ACK_SEED = 6'h2e;
  localparam logic [5:0] ADDR_TRANSCEIVER_STATE_REG = 6'h02;

  localparam int BIT_PROMISCUOUS = 1;
  localparam int BIT_SHORT_ACK = 2;
  localparam int BIT_RES_ACCEPT = 4;
  localparam int BIT_RES_FILTER = 5;
  localparam int BIT_ACK_SUPPRESS = 4;
  localparam int BIT_SLOTTED = 0;
  localparam int BIT_CRC_VALID = 7;
  localparam int TRAC_LSB = 5;

  localparam logic [7:0] EXT_ACK_RESET = 8'h00;
  localparam logic [7:0] RETRY_RESET = 8'h00;
  localparam logic [7:0] SEED_RESET = 8'h00;

  // transaction result codes
  localparam logic [2:0] TRAC_SUCCESS = 3'h0;
  localparam logic [2:0] TRAC_AWAIT_TRIG = 3'h2;
  localparam logic [2:0] TRAC_INVALID = 3'h7;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic is_reserved;
    logic is_data_cmd;
    logic addr_match;
    logic second_ok;
    logic ack_request;
    logic crc_ok;
  } frame_info_t;

  typedef struct packed {
    logic rx_start;
    logic frame_done;
    logic addr_hit;
  } events_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_DELAY = 4'b0010,
    ST_WAIT_TRIG = 4'b0100,
    ST_TRIG_DLY = 4'b1000
  } ack_state_t;
endpackage

// ===== logic/auto_ack_receive_options.sv
// auto-ack receive mode: filtering options, ack timing and slotted ack
//
// Contract
// - promiscuous bit applies relaxed filtering to non-reserved frames only
// - ack suppress bit blocks every ack
// - sniffer: rx start and frame done each
// - crc valid bit updated after each frame
// - reserved accept off discards reserved frames
// - reserved filter bit selects filtered or bypass
// - bypass: done if uncorrupted, no hit, no ack
// - filtered: hit on match, done if match+good
// - filtered reserved ack needs request and done
// - short bit zero: ack after 12 symbols
// - short bit one: ack after 32 us
// - slotted bit lets host time the ack
// - slotted ack waits for trigger rising edge
// - waiting shows awaiting-trigger transaction code
// - slotted ack ready three symbols after frame
// - ack starts 16 us after trigger edge
// - every reception that passes its filter raises frame done
`timescale 1ns/1ps
module auto_ack_receive_options
  import aack_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // register port
  input wire logic reg_write,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // receiver frame path
  input wire logic frame_start,
  input wire logic frame_end,
  input wire frame_info_t frame_info,
  // host trigger pin
  input wire logic sleep_tx_trigger,
  // results
  output events_t events,
  output logic ack_tx_start
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] extended_ack_control, next_extended_ack_control;
  logic [7:0] extended_retry_control, next_extended_retry_control;
  logic [7:0] ack_seed_control, next_ack_seed_control;
  logic crc_valid, next_crc_valid;
  logic [2:0] transaction_result, next_transaction_result;

  logic promiscuous_enable;
  logic short_ack_delay;
  logic reserved_type_accept;
  logic reserved_type_filter;
  logic ack_suppress;
  logic slotted;

  assign promiscuous_enable = extended_ack_control[BIT_PROMISCUOUS];
  assign short_ack_delay = extended_ack_control[BIT_SHORT_ACK];
  assign reserved_type_accept = extended_ack_control[BIT_RES_ACCEPT];
  assign reserved_type_filter = extended_ack_control[BIT_RES_FILTER];
  assign ack_suppress = ack_seed_control[BIT_ACK_SUPPRESS];
  assign slotted = extended_retry_control[BIT_SLOTTED];

  // ---------------------------------------------------------------
  // frame decision
  // ---------------------------------------------------------------
  logic done_ok, hit_ok, ack_ok;

  always_comb begin
    done_ok = 1'b0;
    hit_ok = 1'b0;
    ack_ok = 1'b0;
    if (frame_info.is_reserved) begin
      if (!reserved_type_accept) begin
        done_ok = 1'b0;
      end else if (!reserved_type_filter) begin
        done_ok = frame_info.crc_ok;
      end else begin
        hit_ok = frame_info.addr_match;
        done_ok = frame_info.addr_match && frame_info.crc_ok;
        ack_ok = done_ok && frame_info.ack_request;
      end
    end else if (promiscuous_enable) begin
      // promiscuous reports every frame with second_ok set, bad crc too; host filters later
      hit_ok = frame_info.addr_match;
      done_ok = frame_info.second_ok;
      ack_ok = frame_info.second_ok && frame_info.addr_match && frame_info.crc_ok
               && frame_info.ack_request;
    end else begin
      hit_ok = frame_info.addr_match;
      done_ok = frame_info.addr_match && frame_info.crc_ok;
      ack_ok = done_ok && frame_info.ack_request && frame_info.is_data_cmd;
    end
    if (ack_suppress) begin
      ack_ok = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // register port and status
  // ---------------------------------------------------------------
  always_comb begin
    next_extended_ack_control = extended_ack_control;
    next_extended_retry_control = extended_retry_control;
    next_ack_seed_control = ack_seed_control;
    next_crc_valid = crc_valid;
    if (reg_write && reg_addr == ADDR_EXT_ACK_CTRL) begin
      next_extended_ack_control = reg_wdata;
    end
    if (reg_write && reg_addr == ADDR_EXT_RETRY_CTRL) begin
      next_extended_retry_control = reg_wdata;
    end
    if (reg_write && reg_addr == ADDR_ACK_SEED) begin
      next_ack_seed_control = reg_wdata;
    end
    if (frame_end) begin
      next_crc_valid = frame_info.crc_ok;
    end
  end

  always_comb begin
    case (reg_addr)
      ADDR_SIGNAL_STRENGTH: reg_rdata = 8'(crc_valid) << BIT_CRC_VALID;
      ADDR_EXT_ACK_CTRL: reg_rdata = extended_ack_control;
      ADDR_EXT_RETRY_CTRL: reg_rdata = extended_retry_control;
      ADDR_ACK_SEED: reg_rdata = ack_seed_control;
      ADDR_TRANSCEIVER_STATE_REG: reg_rdata = 8'(transaction_result) << TRAC_LSB;
      default: reg_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      extended_ack_control <= EXT_ACK_RESET;
      extended_retry_control <= RETRY_RESET;
      ack_seed_control <= SEED_RESET;
      crc_valid <= 1'b0;
    end else begin
      extended_ack_control <= next_extended_ack_control;
      extended_retry_control <= next_extended_retry_control;
      ack_seed_control <= next_ack_seed_control;
      crc_valid <= next_crc_valid;
    end
  end

  // ---------------------------------------------------------------
  // events
  // ---------------------------------------------------------------
  events_t next_events;

  always_comb begin
    next_events.rx_start = frame_start;
    next_events.frame_done = frame_end && done_ok;
    next_events.addr_hit = frame_end && hit_ok;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      events <= '0;
    end else begin
      events <= next_events;
    end
  end

  // ---------------------------------------------------------------
  // ack timing
  // ---------------------------------------------------------------
  ack_state_t state, next_state;
  logic [CNT_W-1:0] count, next_count;
  logic trig_prev, next_ack_tx_start;
  logic trig_rise;
  // age of a pending ack; the short and trigger delays are checked against it, not by long sequences
  logic [CNT_W-1:0] ack_age, next_ack_age;
  logic short_armed, next_short_armed, trig_armed, next_trig_armed;

  assign trig_rise = sleep_tx_trigger && !trig_prev;

  always_comb begin
    next_state = state;
    next_count = count;
    next_ack_tx_start = 1'b0;
    next_transaction_result = transaction_result;
    next_ack_age = ack_age + 1'b1;
    next_short_armed = short_armed && !ack_tx_start;
    next_trig_armed = trig_armed && !ack_tx_start;
    case (state)
      ST_IDLE: begin
        if (frame_end && ack_ok) begin
          next_state = ST_DELAY;
          next_transaction_result = TRAC_INVALID;
          next_ack_age = CNT_W'(1);
          if (slotted) begin
            next_count = CNT_W'(ACK_READY_CYC - 1);
          end else if (short_ack_delay) begin
            next_count = CNT_W'(ACK_SHORT_CYC - 1);
            next_short_armed = 1'b1;
          end else begin
            next_count = CNT_W'(ACK_STD_CYC - 1);
          end
        end
      end
      ST_DELAY: begin
        if (count != '0) begin
          next_count = count - 1'b1;
        end else if (slotted) begin
          next_state = ST_WAIT_TRIG;
          next_transaction_result = TRAC_AWAIT_TRIG;
        end else begin
          next_state = ST_IDLE;
          next_ack_tx_start = 1'b1;
          next_transaction_result = TRAC_SUCCESS;
        end
      end
      ST_WAIT_TRIG: begin
        // edge only counts once ack is ready; host must respect spacing
        if (trig_rise) begin
          next_state = ST_TRIG_DLY;
          next_count = CNT_W'(TRIG_TO_TX_CYC - 1);
          next_ack_age = CNT_W'(1);
          next_trig_armed = 1'b1;
        end
      end
      ST_TRIG_DLY: begin
        if (count != '0) begin
          next_count = count - 1'b1;
        end else begin
          next_state = ST_IDLE;
          next_ack_tx_start = 1'b1;
          next_transaction_result = TRAC_SUCCESS;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_count = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      count <= '0;
      trig_prev <= 1'b0;
      ack_tx_start <= 1'b0;
      transaction_result <= TRAC_SUCCESS;
      ack_age <= '0;
      short_armed <= 1'b0;
      trig_armed <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      trig_prev <= sleep_tx_trigger;
      ack_tx_start <= next_ack_tx_start;
      transaction_result <= next_transaction_result;
      ack_age <= next_ack_age;
      short_armed <= next_short_armed;
      trig_armed <= next_trig_armed;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_suppress;
    @(posedge sys_clk) disable iff (!reset_n)
      (ack_suppress && state == ST_IDLE) |=> !(state == ST_DELAY);
  endproperty
  a_suppress: assert property (p_suppress) else $error("ack while suppressed");

  property p_rx_start;
    @(posedge sys_clk) disable iff (!reset_n) frame_start |=> events.rx_start;
  endproperty
  a_rx_start: assert property (p_rx_start) else $error("rx start missing");

  property p_crc;
    @(posedge sys_clk) disable iff (!reset_n)
      frame_end |=> crc_valid == $past(frame_info.crc_ok);
  endproperty
  a_crc: assert property (p_crc) else $error("crc bit stale");

  property p_res_drop;
    @(posedge sys_clk) disable iff (!reset_n)
      (frame_end && frame_info.is_reserved && !reserved_type_accept)
      |=> !events.frame_done && !events.addr_hit;
  endproperty
  a_res_drop: assert property (p_res_drop) else $error("reserved frame kept");

  property p_bypass;
    @(posedge sys_clk) disable iff (!reset_n)
      (frame_end && frame_info.is_reserved && reserved_type_accept && !reserved_type_filter)
      |=> !events.addr_hit && events.frame_done == $past(frame_info.crc_ok);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass handling wrong");

  property p_filtered;
    @(posedge sys_clk) disable iff (!reset_n)
      (frame_end && frame_info.is_reserved && reserved_type_accept && reserved_type_filter)
      |=> events.frame_done == $past(frame_info.addr_match && frame_info.crc_ok);
  endproperty
  a_filtered: assert property (p_filtered) else $error("filtered handling wrong");

  property p_std_delay;
    @(posedge sys_clk) disable iff (!reset_n)
      (state == ST_IDLE && frame_end && ack_ok && !slotted && !short_ack_delay)
      |=> (!ack_tx_start) [*8] ##1 (state == ST_DELAY);
  endproperty
  a_std_delay: assert property (p_std_delay) else $error("std ack too early");

  property p_short_delay;
    @(posedge sys_clk) disable iff (!reset_n)
      short_armed |-> ack_tx_start == (ack_age == CNT_W'(ACK_SHORT_CYC + 1));
  endproperty
  a_short_delay: assert property (p_short_delay) else $error("short ack timing");

  property p_wait_code;
    @(posedge sys_clk) disable iff (!reset_n)
      state == ST_WAIT_TRIG |-> transaction_result == TRAC_AWAIT_TRIG;
  endproperty
  a_wait_code: assert property (p_wait_code) else $error("wait code missing");

  property p_trig;
    @(posedge sys_clk) disable iff (!reset_n)
      trig_armed |-> ack_tx_start == (ack_age == CNT_W'(TRIG_TO_TX_CYC + 1));
  endproperty
  a_trig: assert property (p_trig) else $error("trigger delay wrong");

  c_sniff: cover property (@(posedge sys_clk) promiscuous_enable && events.frame_done);
  c_slot: cover property (@(posedge sys_clk) state == ST_WAIT_TRIG && trig_rise);
  c_ack: cover property (@(posedge sys_clk) ack_tx_start);
endmodule

// ===== test/host_trigger_model.sv
// host model: raises the trigger pin a set time after each frame done
`timescale 1ns/1ps
module host_trigger_model
  import aack_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // control from bench
  input wire logic slot_en,
  input wire logic [CNT_W-1:0] trig_delay,
  // device side
  input wire events_t events,
  output logic sleep_tx_trigger
);
  logic [CNT_W-1:0] cnt;
  // ------------------------------------------
  // trigger timing
  // ------------------------------------------
  // pin drops at each frame done so every slot gets a fresh rising edge
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= '0;
      sleep_tx_trigger <= 1'b0;
    end else if (events.frame_done && slot_en) begin
      cnt <= trig_delay;
      sleep_tx_trigger <= 1'b0;
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
      sleep_tx_trigger <= (cnt == 1);
    end
  end
endmodule

// ===== test/test_auto_ack_receive_options.sv
// testbench for the auto-ack receive options block
`timescale 1ns/1ps
module test_auto_ack_receive_options;
  import aack_pkg::*;
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] seed;
    frame_info_t fi;
    events_t ev;
    logic ack;
  } row_t;
  logic sys_clk, reset_n, reg_write, frame_start, frame_end, sleep_tx_trigger, ack_tx_start;
  logic slot_en;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v;
  logic [CNT_W-1:0] trig_delay;
  frame_info_t frame_info;
  events_t events;
  int n_errors, cmp_count, k, early;
  // in the sniffer row only the ack suppress bit is set besides promiscuous
  row_t rows [9] = '{
    '{8'h00, 8'h00, 6'h1f, 3'b011, 1'b1},
    '{8'h00, 8'h00, 6'h1d, 3'b011, 1'b0},
    '{8'h00, 8'h10, 6'h1f, 3'b011, 1'b0},
    '{8'h00, 8'h00, 6'h2f, 3'b000, 1'b0},
    '{8'h10, 8'h00, 6'h2f, 3'b010, 1'b0},
    '{8'h30, 8'h00, 6'h2f, 3'b011, 1'b1},
    '{8'h30, 8'h00, 6'h27, 3'b000, 1'b0},
    '{8'h30, 8'h00, 6'h2e, 3'b001, 1'b0},
    '{8'h02, 8'h10, 6'h14, 3'b010, 1'b0}};
  logic [5:0] reset_addr [9] = '{ADDR_EXT_ACK_CTRL, ADDR_EXT_RETRY_CTRL, ADDR_ACK_SEED,
    ADDR_SIGNAL_STRENGTH, ADDR_TRANSCEIVER_STATE_REG, 6'h3f, 6'h00, 6'h08, 6'h20};
  auto_ack_receive_options i_auto_ack_receive_options (.sys_clk(sys_clk), .reset_n(reset_n),
    .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .frame_start(frame_start), .frame_end(frame_end), .frame_info(frame_info),
    .sleep_tx_trigger(sleep_tx_trigger), .events(events), .ack_tx_start(ack_tx_start));
  host_trigger_model i_host_trigger_model (.sys_clk(sys_clk), .reset_n(reset_n),
    .slot_en(slot_en), .trig_delay(trig_delay), .events(events),
    .sleep_tx_trigger(sleep_tx_trigger));
  // ------------------------------------------
  // tasks
  // ------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
  // ends on the negedge after the edge that takes frame_end
  task automatic frame(input frame_info_t fi, input events_t ev);
    @(posedge sys_clk);
    frame_start <= 1'b1;
    @(posedge sys_clk);
    frame_start <= 1'b0;
    @(negedge sys_clk);
    check("rx_start", events.rx_start, 1'b1);
    @(posedge sys_clk);
    frame_end <= 1'b1;
    frame_info <= fi;
    reg_addr <= ADDR_SIGNAL_STRENGTH;
    @(posedge sys_clk);
    frame_end <= 1'b0;
    @(negedge sys_clk);
    check("events", events, ev);
    check("crc_valid", reg_rdata[BIT_CRC_VALID], fi.crc_ok);
  endtask
  // i counts negedges from the current one; first ack pulse must land at n
  task automatic wait_ack(input logic exp, input int n);
    int seen;
    seen = -1;
    for (int i = 0; i <= n + 4; i++) begin
      if (i > 0) @(negedge sys_clk);
      if (ack_tx_start === 1'b1 && seen < 0) seen = i;
    end
    check("ack_cycle", seen, exp ? n : -1);
  endtask
  // ------------------------------------------
  // clock, reset, watchdog
  // ------------------------------------------
  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;
  initial begin
    #(60000 * 50);
    n_errors++;
    wrap_up();
  end
  // ------------------------------------------
  // main sequence
  // ------------------------------------------
  initial begin
    reset_n = 1'b0;
    {reg_write, frame_start, frame_end, slot_en} = 4'h0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    frame_info = '0;
    trig_delay = 13'h03e8;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      wr(ADDR_EXT_ACK_CTRL, rows[i].ctl);
      wr(ADDR_ACK_SEED, rows[i].seed);
      frame(rows[i].fi, rows[i].ev);
      wait_ack(rows[i].ack, ACK_STD_CYC);
    end
    // short ack delay of two symbols
    wr(ADDR_EXT_ACK_CTRL, 8'h04);
    wr(ADDR_ACK_SEED, 8'h00);
    frame(6'h1f, 3'b011);
    wait_ack(1'b1, ACK_SHORT_CYC);
    // slotted: host times the ack with the trigger pin
    wr(ADDR_EXT_ACK_CTRL, 8'h00);
    wr(ADDR_EXT_RETRY_CTRL, 8'h01);
    slot_en <= 1'b1;
    frame(6'h1f, 3'b011);
    repeat (500) @(negedge sys_clk);
    rd(ADDR_TRANSCEIVER_STATE_REG, v);
    check("trac_early", v[7:5], TRAC_INVALID);
    repeat (480) @(negedge sys_clk);
    rd(ADDR_TRANSCEIVER_STATE_REG, v);
    check("trac_wait", v[7:5], TRAC_AWAIT_TRIG);
    early = 0;
    k = 0;
    while (sleep_tx_trigger !== 1'b1 && k < 2000) begin
      @(negedge sys_clk);
      if (ack_tx_start === 1'b1) early++;
      k++;
    end
    check("ack_before_trigger", early, 0);
    // pin is seen here one edge before the edge that takes it
    wait_ack(1'b1, TRIG_TO_TX_CYC + 1);
    // reset values, read-back, unmapped place
    @(posedge sys_clk);
    reset_n <= 1'b0;
    @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    check("outputs_after_reset", {events, ack_tx_start}, 4'h0);
    foreach (reset_addr[i]) begin
      rd(reset_addr[i], v);
      check("reset_value", v, 8'h00);
    end
    wr(ADDR_EXT_ACK_CTRL, 8'ha5);
    rd(ADDR_EXT_ACK_CTRL, v);
    check("ext_ack_rw", v, 8'ha5);
    wrap_up();
  end
endmodule
